// ==== rtl/dfr_consts.svh ====
// Offsets, field positions and reset values of the input function router
`ifndef DFR_CONSTS_SVH
`define DFR_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DFR_SEL_BASE 8'h00
`define DFR_CFG_OFS 8'h40
`define DFR_STAT_OFS 8'h44
`define DFR_CMD_OFS 8'h48

// ----------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------
`define DFR_CFG_RUN_EDGE 0
`define DFR_CFG_AN_LSB 1
`define DFR_CFG_AN_MSB 2
`define DFR_CFG_SETSRC 3
`define DFR_CFG_SWSET_LSB 4
`define DFR_CFG_SWSET_MSB 5
`define DFR_CFG_MSB 5

// ----------------------------------------------------------------
// Reset value and widths
// ----------------------------------------------------------------
`define DFR_CFG_RST 6'h00
`define DFR_SEL_WIDTH 5
`define DFR_CMD_WIDTH 20

`endif

// ==== rtl/dfr_pkg.sv ====
// Types shared by the digital input function router
package dfr_pkg;

  // Function selector codes
  typedef enum logic [4:0] {
    DFR_FN_OFF = 5'h00,
    DFR_FN_STOP = 5'h01,
    DFR_FN_RESET = 5'h02,
    DFR_FN_ENABLE = 5'h03,
    DFR_FN_RUN_FORWARD_CMD = 5'h04,
    DFR_FN_RUN_REVERSE_CMD = 5'h05,
    DFR_FN_INCH_FWD = 5'h06,
    DFR_FN_INCH_REV = 5'h07,
    DFR_FN_SET_B0 = 5'h08,
    DFR_FN_SET_B1 = 5'h09,
    DFR_FN_LOCAL = 5'h0A,
    DFR_FN_AN_GATE = 5'h0B,
    DFR_FN_AUTOSET = 5'h0C,
    DFR_FN_SPIN_BRAKE = 5'h0D,
    DFR_FN_ALARM1 = 5'h10,
    DFR_FN_ALARM2 = 5'h11,
    DFR_FN_TIMER1 = 5'h12,
    DFR_FN_TIMER2 = 5'h13,
    DFR_FN_TIMER3 = 5'h14,
    DFR_FN_TIMER4 = 5'h15
  } dfr_fn_t;

  // Analogue input enable modes
  typedef enum logic [1:0] {
    DFR_AN_ALWAYS = 2'h0,
    DFR_AN_GATE_LOW = 2'h1,
    DFR_AN_GATE_HIGH = 2'h2
  } dfr_an_mode_t;

  // Internal command bundle
  typedef struct packed {
    logic stop_req;
    logic reset_pulse;
    logic auto_reset_en;
    logic enable;
    logic run_forward_cmd;
    logic run_reverse_cmd;
    logic inch_forward_cmd;
    logic inch_reverse_cmd;
    logic [1:0] param_set;
    logic local_mode;
    logic analogue_enable_qualifier;
    logic autoset_pulse;
    logic spin_brake;
    logic [1:0] ext_alarm;
    logic [3:0] timer_start;
  } dfr_cmd_t;

endpackage

// ==== rtl/dfr_router.sv ====
// Digital input function router with AHB-Lite register slave
`timescale 1ns/1ps
`include "dfr_consts.svh"

// Functional notes
// - Selector codes 0..11: off, stop, reset, enable, run, inch, set bits, local, gate.
// - Codes 12 autoset, 13 spin brake, 16/17 alarms, 18..21 timers; 0 inactive.
// - Four base input terminals.
// - Inputs sharing one function are ORed unless stated otherwise.
// - Stop is active low; stop inputs ANDed so any low input stops.
// - Trip reset on input edge only; auto reset enable follows level.
// - Enable input low cuts output immediately, no ramp.
// - Enable inputs ANDed; none configured keeps enable asserted.
// - Inch inputs always level sensitive, giving run in their direction.
// - Autoset triggers on edge only, whatever the run-control mode.
// - Alarm one is active low and ORed; open input trips at once.
// - Alarm two is active low; open or low input trips at once.
// - Timer triggers start on input rising edge only.
// - Set bits form code, bit one least significant: A,B,C,D.
// - Input set selection applies only when set source is inputs.
// - Local input selects local mode; gate input feeds analogue qualifier.
// - Spin brake accepted from inactive state too.
// - Reset defaults: run forward, stop, set bit one, reset.
// - Expansion inputs offer same codes and default to off.
// - Analogue enable: always, only gate low (1), only gate high (2).
module dfr_router #(
  parameter int NUM_BASE = 4,
  parameter int NUM_EXP = 6
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Input terminals
  input wire logic [NUM_BASE-1:0] input_terminal_i,
  input wire logic [NUM_EXP-1:0] expansion_input_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Internal commands
  output dfr_pkg::dfr_cmd_t cmd_o
);

  localparam int NUM_IN = NUM_BASE + NUM_EXP;
  localparam int NUM_FN = 32;

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] sync1_reg;
  logic [NUM_IN-1:0] sync2_reg;
  logic [NUM_IN-1:0] prev_reg;
  logic [NUM_IN-1:0] rise;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= {expansion_input_i, input_terminal_i};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // One pulse per low-to-high step of the settled level
  assign rise = sync2_reg & ~prev_reg;

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic take;
  logic [31:0] rd_mux;

  assign take = hsel_i & htrans_i[1] & hready_i;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take & hwrite_i;
      if (take) begin
        addr_reg <= haddr_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Function selectors and decode
  // ----------------------------------------------------------------
  logic [4:0] sel_reg [NUM_IN];
  logic [NUM_IN-1:0] hit [NUM_FN];

  genvar gi, gf;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      // Base terminals have their own defaults, expansion ones are off
      localparam logic [4:0] RST_SEL =
        (gi == 0) ? dfr_pkg::DFR_FN_RUN_FORWARD_CMD :
        (gi == 1) ? dfr_pkg::DFR_FN_STOP :
        (gi == 2) ? dfr_pkg::DFR_FN_SET_B0 :
        (gi == 3) ? dfr_pkg::DFR_FN_RESET :
        dfr_pkg::DFR_FN_OFF;
      localparam logic [7:0] SEL_OFS = 8'(`DFR_SEL_BASE + 4 * gi);

      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          sel_reg[gi] <= RST_SEL;
        end else if (wr_pend_reg && addr_reg == SEL_OFS) begin
          sel_reg[gi] <= hwdata_i[4:0];
        end
      end

      for (gf = 0; gf < NUM_FN; gf++) begin : g_fn
        // Unused codes match no function and leave the input idle
        assign hit[gf][gi] = (sel_reg[gi] == 5'(gf));
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Per-function combining
  // ----------------------------------------------------------------
  logic [NUM_FN-1:0] any_f;
  logic [NUM_FN-1:0] or_f;
  logic [NUM_FN-1:0] and_f;
  logic [NUM_FN-1:0] low_f;
  logic [NUM_FN-1:0] rise_f;

  generate
    for (gf = 0; gf < NUM_FN; gf++) begin : g_comb
      assign any_f[gf] = |hit[gf];
      assign or_f[gf] = |(hit[gf] & sync2_reg);
      assign and_f[gf] = &(~hit[gf] | sync2_reg);
      assign low_f[gf] = |(hit[gf] & ~sync2_reg);
      assign rise_f[gf] = |(hit[gf] & rise);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  logic [`DFR_CFG_MSB:0] cfg_reg;
  logic run_edge;
  logic set_from_in;
  dfr_pkg::dfr_an_mode_t an_mode;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg_reg <= `DFR_CFG_RST;
    end else if (wr_pend_reg && addr_reg == `DFR_CFG_OFS) begin
      cfg_reg <= hwdata_i[`DFR_CFG_MSB:0];
    end
  end

  assign run_edge = cfg_reg[`DFR_CFG_RUN_EDGE];
  assign set_from_in = cfg_reg[`DFR_CFG_SETSRC];
  assign an_mode = dfr_pkg::dfr_an_mode_t'(
    cfg_reg[`DFR_CFG_AN_MSB:`DFR_CFG_AN_LSB]);

  // ----------------------------------------------------------------
  // Command generation
  // ----------------------------------------------------------------
  dfr_pkg::dfr_cmd_t cmd_next;
  dfr_pkg::dfr_cmd_t cmd_reg;
  logic gate_lvl;

  assign gate_lvl = or_f[dfr_pkg::DFR_FN_AN_GATE];

  always_comb begin
    cmd_next = '0;
    // Low on any stop input requests a stop
    cmd_next.stop_req = any_f[dfr_pkg::DFR_FN_STOP] &
      ~and_f[dfr_pkg::DFR_FN_STOP];
    cmd_next.reset_pulse = rise_f[dfr_pkg::DFR_FN_RESET];
    cmd_next.auto_reset_en = or_f[dfr_pkg::DFR_FN_RESET];
    // No enable terminal means enabled; drop is not ramped
    cmd_next.enable = and_f[dfr_pkg::DFR_FN_ENABLE];
    if (run_edge) begin
      cmd_next.run_forward_cmd = rise_f[dfr_pkg::DFR_FN_RUN_FORWARD_CMD];
      cmd_next.run_reverse_cmd = rise_f[dfr_pkg::DFR_FN_RUN_REVERSE_CMD];
    end else begin
      cmd_next.run_forward_cmd = or_f[dfr_pkg::DFR_FN_RUN_FORWARD_CMD];
      cmd_next.run_reverse_cmd = or_f[dfr_pkg::DFR_FN_RUN_REVERSE_CMD];
    end
    // Inch ignores the run-control mode
    cmd_next.inch_forward_cmd = or_f[dfr_pkg::DFR_FN_INCH_FWD];
    cmd_next.inch_reverse_cmd = or_f[dfr_pkg::DFR_FN_INCH_REV];
    if (set_from_in) begin
      cmd_next.param_set = {or_f[dfr_pkg::DFR_FN_SET_B1],
        or_f[dfr_pkg::DFR_FN_SET_B0]};
    end else begin
      cmd_next.param_set =
        cfg_reg[`DFR_CFG_SWSET_MSB:`DFR_CFG_SWSET_LSB];
    end
    cmd_next.local_mode = or_f[dfr_pkg::DFR_FN_LOCAL];
    case (an_mode)
      dfr_pkg::DFR_AN_GATE_LOW: begin
        cmd_next.analogue_enable_qualifier = ~gate_lvl;
      end
      dfr_pkg::DFR_AN_GATE_HIGH: begin
        cmd_next.analogue_enable_qualifier = gate_lvl;
      end
      default: begin
        cmd_next.analogue_enable_qualifier = 1'b1;
      end
    endcase
    cmd_next.autoset_pulse = rise_f[dfr_pkg::DFR_FN_AUTOSET];
    // No run-state gating, so it works while stopped
    cmd_next.spin_brake = or_f[dfr_pkg::DFR_FN_SPIN_BRAKE];
    cmd_next.ext_alarm[0] = low_f[dfr_pkg::DFR_FN_ALARM1];
    cmd_next.ext_alarm[1] = low_f[dfr_pkg::DFR_FN_ALARM2];
    cmd_next.timer_start = {rise_f[dfr_pkg::DFR_FN_TIMER4],
      rise_f[dfr_pkg::DFR_FN_TIMER3],
      rise_f[dfr_pkg::DFR_FN_TIMER2],
      rise_f[dfr_pkg::DFR_FN_TIMER1]};
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  assign cmd_o = cmd_reg;

  // ----------------------------------------------------------------
  // Read data and response
  // ----------------------------------------------------------------
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr_i[7:2] < 6'(NUM_IN)) begin
      rd_mux[4:0] = sel_reg[haddr_i[5:2]];
    end else if (haddr_i[7:0] == `DFR_CFG_OFS) begin
      rd_mux[`DFR_CFG_MSB:0] = cfg_reg;
    end else if (haddr_i[7:0] == `DFR_STAT_OFS) begin
      rd_mux[NUM_IN-1:0] = sync2_reg;
    end else if (haddr_i[7:0] == `DFR_CMD_OFS) begin
      rd_mux[`DFR_CMD_WIDTH-1:0] = cmd_reg;
    end
  end

  // Data captured in address phase so no wait states
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Reset drops on a clock edge, so checks stay quiet one edge longer
  logic rst_hold_reg;

  always_ff @(posedge sys_clk_i) begin
    rst_hold_reg <= sys_rst_i;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i || rst_hold_reg);

  property p_sync;
    $past(input_terminal_i, 2) == sync2_reg[NUM_BASE-1:0];
  endproperty
  a_sync: assert property (p_sync)
    else $error("input not settled two cycles later");

  property p_stop;
    low_f[dfr_pkg::DFR_FN_STOP] |=> cmd_o.stop_req;
  endproperty
  a_stop: assert property (p_stop)
    else $error("low stop input did not request stop");

  property p_enable_none;
    !any_f[dfr_pkg::DFR_FN_ENABLE] |=> cmd_o.enable;
  endproperty
  a_enable_none: assert property (p_enable_none)
    else $error("enable not held without enable input");

  property p_enable_drop;
    low_f[dfr_pkg::DFR_FN_ENABLE] |=> !cmd_o.enable;
  endproperty
  a_enable_drop: assert property (p_enable_drop)
    else $error("enable not cut one cycle after low input");

  property p_reset_edge;
    !rise_f[dfr_pkg::DFR_FN_RESET] |=> !cmd_o.reset_pulse;
  endproperty
  a_reset_edge: assert property (p_reset_edge)
    else $error("reset pulse without an input edge");

  property p_inch;
    run_edge && or_f[dfr_pkg::DFR_FN_INCH_FWD] [*2]
      |=> cmd_o.inch_forward_cmd;
  endproperty
  a_inch: assert property (p_inch)
    else $error("inch forward not level held");

  property p_autoset;
    !run_edge && or_f[dfr_pkg::DFR_FN_AUTOSET]
      && !rise_f[dfr_pkg::DFR_FN_AUTOSET] |=> !cmd_o.autoset_pulse;
  endproperty
  a_autoset: assert property (p_autoset)
    else $error("autoset repeated on a held level");

  property p_alarm1;
    low_f[dfr_pkg::DFR_FN_ALARM1] |=> cmd_o.ext_alarm[0];
  endproperty
  a_alarm1: assert property (p_alarm1)
    else $error("alarm one not raised by low input");

  property p_alarm2;
    !low_f[dfr_pkg::DFR_FN_ALARM2] |=> !cmd_o.ext_alarm[1];
  endproperty
  a_alarm2: assert property (p_alarm2)
    else $error("alarm two raised without low input");

  property p_timer;
    $rose(sync2_reg[0]) && hit[dfr_pkg::DFR_FN_TIMER1][0]
      |=> cmd_o.timer_start[0] ##1 !cmd_o.timer_start[0] || rise[0];
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer one start not a single pulse");

  property p_set_c;
    set_from_in && !or_f[dfr_pkg::DFR_FN_SET_B0]
      && or_f[dfr_pkg::DFR_FN_SET_B1] |=> cmd_o.param_set == 2'h2;
  endproperty
  a_set_c: assert property (p_set_c)
    else $error("set bits did not select set C");

  property p_an_low;
    an_mode == dfr_pkg::DFR_AN_GATE_LOW && gate_lvl
      |=> !cmd_o.analogue_enable_qualifier;
  endproperty
  a_an_low: assert property (p_an_low)
    else $error("analogue qualifier active with gate high");

  property p_defaults;
    $past(sys_rst_i) |-> sel_reg[0] == dfr_pkg::DFR_FN_RUN_FORWARD_CMD
      && sel_reg[1] == dfr_pkg::DFR_FN_STOP
      && sel_reg[2] == dfr_pkg::DFR_FN_SET_B0
      && sel_reg[3] == dfr_pkg::DFR_FN_RESET
      && sel_reg[NUM_IN-1] == dfr_pkg::DFR_FN_OFF;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("selector defaults wrong after reset");

  c_stop: cover property (cmd_o.stop_req ##1 !cmd_o.stop_req);
  c_timer: cover property (cmd_o.timer_start[0]);
  c_write: cover property (wr_pend_reg ##2 take && !hwrite_i);
  c_set_d: cover property (cmd_o.param_set == 2'h3);

endmodule

// ==== verif/dfr_switch_model.sv ====
// External switch contacts wired to the input terminals
`timescale 1ns/1ps
module dfr_switch_model (
  // Contact state
  input wire logic [9:0] closed_i,
  input wire logic [9:0] wired_i,
  // Terminal levels
  output logic [9:0] term_o
);
  // Open terminal reads low, so alarms trip at once
  assign term_o = wired_i & closed_i;
endmodule

// ==== verif/tb_digital_input_function_router.sv ====
// Self-checking bench for the input function router
`timescale 1ns/1ps
module tb_digital_input_function_router;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  dfr_pkg::dfr_cmd_t cmd;
  logic [9:0] closed = 10'h0;
  logic [9:0] wired = 10'h0;
  logic [9:0] term;
  logic [5:0] cfg = 6'h0;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 50;
  int cyc = 0;
  int cnt;
  int sel[10];
  int dflt[4] = '{4, 1, 8, 2};
  int ecode[7] = '{2, 12, 18, 19, 20, 21, 4};
  int ebit[7] = '{18, 7, 0, 1, 2, 3, 15};

  always #5 sys_clk_i = ~sys_clk_i;

  dfr_switch_model SW (
    .closed_i(closed),
    .wired_i(wired),
    .term_o(term)
  );

  dfr_router DUT (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .input_terminal_i(term[3:0]),
    .expansion_input_i(term[9:4]),
    .hsel_i(hsel),
    .haddr_i(haddr),
    .htrans_i(htrans),
    .hwrite_i(hwrite),
    .hsize_i(3'h2),
    .hwdata_i(hwdata),
    .hready_i(hready),
    .hrdata_o(hrdata),
    .hreadyout_o(hready),
    .hresp_o(hresp),
    .cmd_o(cmd)
  );

  // ------------------------------------------------------------
  // Tasks and reference model
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Pulse fields except run reverse are checked by counting, not by level
  function automatic logic [19:0] msk();
    return 20'hBFF70 & ~(cfg[0] ? 20'h0C000 : 20'h0);
  endfunction

  function automatic logic [19:0] model();
    dfr_pkg::dfr_cmd_t e;
    logic [9:0] v;
    logic st;
    logic en;
    logic gate;
    e = '0;
    v = closed & wired;
    st = 1'b0;
    en = 1'b1;
    gate = 1'b0;
    for (int i = 0; i < 10; i++) begin
      case (sel[i])
        1: st |= !v[i];
        2: e.auto_reset_en |= v[i];
        3: en &= v[i];
        4: e.run_forward_cmd |= v[i] & !cfg[0];
        5: e.run_reverse_cmd |= v[i] & !cfg[0];
        6: e.inch_forward_cmd |= v[i];
        7: e.inch_reverse_cmd |= v[i];
        8: e.param_set[0] |= v[i];
        9: e.param_set[1] |= v[i];
        10: e.local_mode |= v[i];
        11: gate |= v[i];
        13: e.spin_brake |= v[i];
        16: e.ext_alarm[0] |= !v[i];
        17: e.ext_alarm[1] |= !v[i];
        default: ;
      endcase
    end
    e.stop_req = st;
    e.enable = en;
    if (!cfg[3]) e.param_set = cfg[5:4];
    e.analogue_enable_qualifier = (cfg[2:1] == 2'h1) ? !gate :
      (cfg[2:1] == 2'h2) ? gate : 1'b1;
    return e;
  endfunction

  // ------------------------------------------------------------
  // Hang guard and main sequence
  // ------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    logic [31:0] q;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0, q);
      chk("sel", (i < 4) ? 32'(dflt[i]) : 32'h0, q);
    end
    bus(1'b1, 8'h80, 32'h1F, q);
    bus(1'b0, 8'h80, 32'h0, q);
    chk("unmapped", 32'h0, q);
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 10; i++) begin
        sel[i] = $unsigned($random(seed)) % 22;
        bus(1'b1, 8'(4 * i), 32'(sel[i]), q);
      end
      cfg = 6'($random(seed));
      bus(1'b1, 8'h40, {26'h0, cfg}, q);
      bus(1'b0, 8'h40, 32'h0, q);
      chk("cfg", {26'h0, cfg}, q);
      closed <= 10'($random(seed));
      wired <= 10'($random(seed) | $random(seed));
      repeat (5) @(posedge sys_clk_i);
      chk("cmd", {12'h0, model() & msk()}, {12'h0, cmd & msk()});
      bus(1'b0, 8'h48, 32'h0, q);
      chk("cmd reg", {12'h0, model() & msk()}, q & {12'h0, msk()});
      bus(1'b0, 8'h44, 32'h0, q);
      chk("status", {22'h0, closed & wired}, q);
    end
    // Edge functions: one pulse per rising contact, level held after
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, 8'(4 * i), 32'h0, q);
    end
    wired <= 10'h3FF;
    closed <= 10'h0;
    for (int j = 0; j < 7; j++) begin
      bus(1'b1, 8'h14, 32'(ecode[j]), q);
      bus(1'b1, 8'h40, {31'h0, ecode[j] == 4}, q);
      repeat (5) @(posedge sys_clk_i);
      closed <= 10'h020;
      cnt = 0;
      repeat (8) begin
        @(posedge sys_clk_i);
        cnt += int'(cmd[ebit[j]] === 1'b1);
      end
      chk("pulses", 32'h1, 32'(cnt));
      closed <= 10'h0;
    end
    test_done();
  end
endmodule
